// >>> hdl/scc_pkg.sv
// Constants for the system controller cache, hole and cycle register bank.
// Assumes an Avalon-MM slave with word addresses equal to index times four.
package scc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] IDX_CPU_CACHE = 8'h08;
    localparam logic [7:0] IDX_HOLE_FUNC = 8'h09;
    localparam logic [7:0] IDX_HOLE_A_LO = 8'h0a;
    localparam logic [7:0] IDX_HOLE_B_LO = 8'h0b;
    localparam logic [7:0] IDX_HOLE_HI = 8'h0c;
    localparam logic [7:0] IDX_CLK_SKEW = 8'h0d;
    localparam logic [7:0] IDX_CYC_ONE = 8'h0e;
    localparam logic [7:0] IDX_CYC_TWO = 8'h0f;
    localparam logic [7:0] IDX_CYC_PIPE = 8'h10;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // Bit positions.
    localparam int unsigned B_BIOS_NC = 0;
    localparam int unsigned B_L1_WB = 1;
    localparam int unsigned B_PAR_EN = 4;
    localparam int unsigned B_FILT_EN = 6;
    localparam int unsigned B_FAST_CPU_BURST_READY = 6;
    localparam int unsigned B_EXTERNAL_SRAM_CLOCK_SRC = 7;
    localparam int unsigned B_SKEW_RO = 6;
    localparam int unsigned B_AUTO_SKEW = 5;
    localparam int unsigned B_SKEW_RW = 4;
    localparam int unsigned B_AB_SYS = 3;
    localparam int unsigned B_TOGGLE486 = 2;
    localparam int unsigned B_CLAIM = 1;
    localparam int unsigned B_MPAR_DIS = 3;
    localparam int unsigned B_ALE_TIME = 2;
    localparam int unsigned B_BIOS_WP = 1;
    localparam int unsigned B_LINE_CMP = 0;
    localparam int unsigned B_PRESNOOP = 7;
    localparam int unsigned B_EVEN_WS = 5;
    localparam int unsigned B_SRAM_CONTROLLER_ADDR_STROBE_LATE = 2;
    localparam int unsigned B_EARLY_DEC = 7;
    localparam int unsigned B_PIPE_RD = 5;
    localparam int unsigned B_EXT_BIOS = 0;
    // Reserved bits that read as zero.
    localparam logic [7:0] MASK_HOLE_HI = 8'h7f;
    localparam logic [7:0] MASK_CYC_TWO = 8'hf7;
    // Hole mode codes.
    localparam logic [1:0] HM_OFF = 2'h0;
    localparam logic [1:0] HM_WT = 2'h1;
    localparam logic [1:0] HM_NC = 2'h2;
    localparam logic [1:0] HM_REMOVE = 2'h3;
    // Cycle counts.
    localparam logic [2:0] CPU_BURST_READY_SLOW = 3'h4;
    localparam logic [2:0] CPU_BURST_READY_FAST = 3'h3;
    localparam logic [2:0] LEAD_SLOW = 3'h3;
    localparam logic [2:0] LEAD_FAST = 3'h2;
    localparam logic [2:0] PCI_WS_4 = 3'h4;
    localparam logic [2:0] PCI_WS_3 = 3'h3;
    localparam logic [2:0] PCI_WS_2 = 3'h2;
    localparam logic [2:0] T2_SECOND = 3'h2;
    localparam logic [2:0] T2_FIRST = 3'h1;
    // Host address ranges in units of 64 KB (bits 19:16 of the address).
    localparam logic [3:0] SEG_A = 4'ha;
    localparam logic [3:0] SEG_B = 4'hb;
    localparam logic [3:0] SEG_C = 4'hc;
    localparam logic [3:0] SEG_E = 4'he;
    localparam logic [3:0] SEG_F = 4'hf;
    localparam int unsigned HOLE_LSB = 19;
    localparam int unsigned HOLE_MSB = 28;
endpackage

// >>> hdl/scc_hole_match.sv
// One programmable DRAM hole: size decode and start address compare.
// Assumes the host address is registered on the same clock.
`timescale 1ns/1ps
module scc_hole_match (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration
    input wire logic [1:0] size,
    input wire logic [1:0] mode,
    input wire logic [9:0] start,
    // Host address and result
    input wire logic [31:0] addr,
    output logic hit_q
);
    // Size 512KB << n masks off n low bits of the 10-bit start compare.
    logic [9:0] cmp_mask;
    logic match;
    assign cmp_mask = 10'h3ff << size;
    assign match = ((addr[scc_pkg::HOLE_MSB:scc_pkg::HOLE_LSB] ^ start)
                   & cmp_mask) == 10'h000;
    always_ff @(posedge clock) begin
        if (rst) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= match && (mode != scc_pkg::HM_OFF);
        end
    end
endmodule

// >>> hdl/scc_regs.sv
// Cache, hole and cycle control register bank of the system controller.
// Assumes a synchronous Avalon-MM master on the same clock and an
// external SRAM skew detector whose flag arrives asynchronously.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module scc_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Host cycle observation
    input wire logic [31:0] host_address_bus,
    input wire logic skew_excess_async,
    input wire logic cpu_modified_hit,
    input wire logic pci_presnoop_cycle,
    input wire logic pci_master_toggle,
    input wire logic pci_frame_start,
    input wire logic sram_even_byte,
    // Cache and memory policy
    output logic l1_writeback_en_q,
    output logic l1_cacheable_q,
    output logic l1_write_protect_q,
    output logic hole_writethrough_q,
    output logic hole_noncache_q,
    output logic hole_remove_q,
    output logic system_memory_q,
    output logic parity_check_q,
    // Cycle timing
    output logic [2:0] write_ready_clock_q,
    output logic [2:0] pipe_leadoff_q,
    output logic [2:0] pci_read_waits_q,
    output logic [2:0] pci_write_waits_q,
    output logic [2:0] slave_trigger_t2_q,
    output logic pci_extra_wait_q,
    output logic sram_extra_wait_q,
    output logic sram_strobe_delay_q,
    output logic sram_clock_ext_q,
    output logic cache_addr_latch_enable_q,
    output logic cache_address_bit_four_q,
    // Snoop control
    output logic pci_stop_q,
    output logic pci_claim_q,
    output logic inquire_q
);
    logic [7:0] cpu_cache_q, hole_func_q, hole_a_lo_q, hole_b_lo_q;
    logic [7:0] hole_hi_q, clk_skew_q, cyc_one_q, cyc_two_q, cyc_pipe_q;
    logic [7:0] idx;
    logic hit, sel_write, mapped, ack_q;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic skew_s1_q, skew_s2_q;
    logic skew_seen;
    logic hole_a_hit, hole_b_hit;
    logic [3:0] seg;
    logic in_bios, in_video, in_ab;
    logic mod_hit_q;

    function automatic logic [2:0] pci_waits(input logic [1:0] code);
        unique case (code)
            2'h0: pci_waits = scc_pkg::PCI_WS_4;
            2'h1: pci_waits = scc_pkg::PCI_WS_3;
            2'h2: pci_waits = scc_pkg::PCI_WS_2;
            // Reserved code keeps the slowest setting.
            2'h3: pci_waits = scc_pkg::PCI_WS_4;
        endcase
    endfunction

    function automatic logic [7:0] upd(input logic [7:0] old,
                                       input logic [7:0] mask);
        upd = (sel_write && (idx == 8'h00)) ? old : ((wbyte & mask) | 8'h00);
    endfunction

    // Bus decode: one 8-bit register per aligned word.
    assign idx = avs_address[9:2];
    assign hit = avs_read || avs_write;
    assign mapped = (idx >= scc_pkg::IDX_CPU_CACHE) &&
                    (idx <= scc_pkg::IDX_CYC_PIPE);
    // The write lands at the answer edge, where the master sees the ack.
    assign sel_write = avs_write && ack_q && avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign rd_byte =
        (idx == scc_pkg::IDX_CPU_CACHE) ? cpu_cache_q :
        (idx == scc_pkg::IDX_HOLE_FUNC) ? hole_func_q :
        (idx == scc_pkg::IDX_HOLE_A_LO) ? hole_a_lo_q :
        (idx == scc_pkg::IDX_HOLE_B_LO) ? hole_b_lo_q :
        (idx == scc_pkg::IDX_HOLE_HI) ? hole_hi_q :
        (idx == scc_pkg::IDX_CLK_SKEW) ? clk_skew_q :
        (idx == scc_pkg::IDX_CYC_ONE) ? cyc_one_q :
        (idx == scc_pkg::IDX_CYC_TWO) ? cyc_two_q :
        (idx == scc_pkg::IDX_CYC_PIPE) ? cyc_pipe_q : scc_pkg::RESET_VAL;

    // One wait cycle per access: the answer comes at the second edge.
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else begin
            ack_q <= hit && !ack_q;
            // Kept as a flop of its own so the pin never glitches.
            avs_waitrequest <= !(hit && !ack_q);
            avs_readdata <= {24'h00_0000, rd_byte};
            // Unmapped indices answer with a decode error.
            avs_response <= mapped ? 2'h0 : 2'h3;
        end
    end
    // The skew flag is a level from another domain.
    always_ff @(posedge clock) begin
        if (rst) begin
            skew_s1_q <= 1'b0;
            skew_s2_q <= 1'b0;
        end else begin
            skew_s1_q <= skew_excess_async;
            skew_s2_q <= skew_s1_q;
        end
    end
    // Detection only runs while auto detect is on.
    assign skew_seen = skew_s2_q && clk_skew_q[scc_pkg::B_AUTO_SKEW];

    always_ff @(posedge clock) begin
        if (rst) begin
            cpu_cache_q <= scc_pkg::RESET_VAL;
            hole_func_q <= scc_pkg::RESET_VAL;
            hole_a_lo_q <= scc_pkg::RESET_VAL;
            hole_b_lo_q <= scc_pkg::RESET_VAL;
            hole_hi_q <= scc_pkg::RESET_VAL;
            clk_skew_q <= scc_pkg::RESET_VAL;
            cyc_one_q <= scc_pkg::RESET_VAL;
            cyc_two_q <= scc_pkg::RESET_VAL;
            cyc_pipe_q <= scc_pkg::RESET_VAL;
        end else begin
            if (sel_write && idx == scc_pkg::IDX_CPU_CACHE) begin
                cpu_cache_q <= wbyte;
            end
            if (sel_write && idx == scc_pkg::IDX_HOLE_FUNC) begin
                hole_func_q <= wbyte;
            end
            if (sel_write && idx == scc_pkg::IDX_HOLE_A_LO) begin
                hole_a_lo_q <= wbyte;
            end
            if (sel_write && idx == scc_pkg::IDX_HOLE_B_LO) begin
                hole_b_lo_q <= wbyte;
            end
            if (sel_write && idx == scc_pkg::IDX_HOLE_HI) begin
                hole_hi_q <= wbyte & scc_pkg::MASK_HOLE_HI;
            end
            if (sel_write && idx == scc_pkg::IDX_CYC_ONE) begin
                cyc_one_q <= wbyte;
            end
            if (sel_write && idx == scc_pkg::IDX_CYC_TWO) begin
                cyc_two_q <= wbyte & scc_pkg::MASK_CYC_TWO;
            end
            if (sel_write && idx == scc_pkg::IDX_CYC_PIPE) begin
                cyc_pipe_q <= wbyte;
            end
            // Status bit is hardware owned; the writable skew bit loses
            // to a detection in the same cycle.
            if (sel_write && idx == scc_pkg::IDX_CLK_SKEW) begin
                clk_skew_q[7] <= wbyte[7];
                clk_skew_q[5:0] <= wbyte[5:0];
            end
            if (skew_seen) begin
                clk_skew_q[scc_pkg::B_SKEW_RW] <= 1'b1;
            end
            clk_skew_q[scc_pkg::B_SKEW_RO] <= skew_s2_q;
        end
    end

    // Hole matchers.
    scc_hole_match u_hole_a (
        .clock(clock),
        .rst(rst),
        .size(hole_func_q[3:2]),
        .mode(hole_func_q[1:0]),
        .start({hole_hi_q[1:0], hole_a_lo_q}),
        .addr(host_address_bus),
        .hit_q(hole_a_hit)
    );
    scc_hole_match u_hole_b (
        .clock(clock),
        .rst(rst),
        .size(hole_func_q[7:6]),
        .mode(hole_func_q[5:4]),
        .start({hole_hi_q[3:2], hole_b_lo_q}),
        .addr(host_address_bus),
        .hit_q(hole_b_hit)
    );

    // Low megabyte segment decode for BIOS and A/B ranges.
    assign seg = host_address_bus[19:16];
    assign in_ab = (host_address_bus[31:20] == 12'h000) &&
                   (seg == scc_pkg::SEG_A || seg == scc_pkg::SEG_B);
    assign in_video = (host_address_bus[31:20] == 12'h000) &&
                      (seg == scc_pkg::SEG_C) && !host_address_bus[15];
    assign in_bios = (host_address_bus[31:20] == 12'h000) &&
                     (seg == scc_pkg::SEG_F ||
                      (seg == scc_pkg::SEG_E &&
                       cyc_pipe_q[scc_pkg::B_EXT_BIOS]));

    always_ff @(posedge clock) begin
        if (rst) begin
            l1_writeback_en_q <= 1'b0;
            l1_cacheable_q <= 1'b0;
            l1_write_protect_q <= 1'b0;
            hole_writethrough_q <= 1'b0;
            hole_noncache_q <= 1'b0;
            hole_remove_q <= 1'b0;
            system_memory_q <= 1'b0;
            parity_check_q <= 1'b0;
        end else begin
            l1_writeback_en_q <= cpu_cache_q[scc_pkg::B_L1_WB];
            l1_cacheable_q <= !((in_bios || in_video) &&
                cpu_cache_q[scc_pkg::B_BIOS_NC]);
            l1_write_protect_q <= in_bios &&
                cyc_one_q[scc_pkg::B_BIOS_WP];
            hole_writethrough_q <=
                (hole_a_hit && hole_func_q[1:0] == scc_pkg::HM_WT) ||
                (hole_b_hit && hole_func_q[5:4] == scc_pkg::HM_WT);
            hole_noncache_q <=
                (hole_a_hit && hole_func_q[1:0] == scc_pkg::HM_NC) ||
                (hole_b_hit && hole_func_q[5:4] == scc_pkg::HM_NC);
            hole_remove_q <=
                (hole_a_hit && hole_func_q[1:0] == scc_pkg::HM_REMOVE) ||
                (hole_b_hit && hole_func_q[5:4] == scc_pkg::HM_REMOVE);
            system_memory_q <= in_ab &&
                clk_skew_q[scc_pkg::B_AB_SYS];
            parity_check_q <= cpu_cache_q[scc_pkg::B_PAR_EN] &&
                !cyc_one_q[scc_pkg::B_MPAR_DIS];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            write_ready_clock_q <= scc_pkg::CPU_BURST_READY_SLOW;
            pipe_leadoff_q <= scc_pkg::LEAD_SLOW;
            pci_read_waits_q <= scc_pkg::PCI_WS_4;
            pci_write_waits_q <= scc_pkg::PCI_WS_4;
            slave_trigger_t2_q <= scc_pkg::T2_SECOND;
            pci_extra_wait_q <= 1'b0;
            sram_extra_wait_q <= 1'b0;
            sram_strobe_delay_q <= 1'b0;
            sram_clock_ext_q <= 1'b0;
        end else begin
            write_ready_clock_q <= hole_hi_q[scc_pkg::B_FAST_CPU_BURST_READY] ?
                scc_pkg::CPU_BURST_READY_FAST : scc_pkg::CPU_BURST_READY_SLOW;
            pipe_leadoff_q <= cyc_pipe_q[scc_pkg::B_PIPE_RD] ?
                scc_pkg::LEAD_FAST : scc_pkg::LEAD_SLOW;
            pci_read_waits_q <= pci_waits(cyc_one_q[7:6]);
            pci_write_waits_q <= pci_waits(cyc_one_q[5:4]);
            slave_trigger_t2_q <= cyc_pipe_q[scc_pkg::B_EARLY_DEC] ?
                scc_pkg::T2_FIRST : scc_pkg::T2_SECOND;
            pci_extra_wait_q <= pci_master_toggle &&
                clk_skew_q[scc_pkg::B_TOGGLE486];
            sram_extra_wait_q <= sram_even_byte &&
                cyc_two_q[scc_pkg::B_EVEN_WS];
            sram_strobe_delay_q <= cyc_two_q[scc_pkg::B_SRAM_CONTROLLER_ADDR_STROBE_LATE];
            sram_clock_ext_q <= clk_skew_q[scc_pkg::B_EXTERNAL_SRAM_CLOCK_SRC];
        end
    end

    // Snoop side: pins arrive from the CPU and PCI logic on this clock.
    always_ff @(posedge clock) begin
        if (rst) begin
            mod_hit_q <= 1'b0;
            pci_stop_q <= 1'b0;
            pci_claim_q <= 1'b0;
            inquire_q <= 1'b0;
            cache_addr_latch_enable_q <= 1'b0;
            cache_address_bit_four_q <= 1'b0;
        end else begin
            mod_hit_q <= cpu_modified_hit;
            pci_stop_q <= cpu_modified_hit && pci_presnoop_cycle &&
                cyc_two_q[scc_pkg::B_PRESNOOP];
            // Claim follows the stop by one clock.
            pci_claim_q <= pci_stop_q &&
                clk_skew_q[scc_pkg::B_CLAIM];
            inquire_q <= pci_frame_start &&
                cpu_cache_q[scc_pkg::B_FILT_EN] &&
                cyc_one_q[scc_pkg::B_LINE_CMP];
            cache_addr_latch_enable_q <= cpu_modified_hit &&
                !cyc_one_q[scc_pkg::B_ALE_TIME];
            cache_address_bit_four_q <= cpu_modified_hit &&
                cyc_one_q[scc_pkg::B_ALE_TIME];
        end
    end
endmodule

// >>> sim/scc_regs_assertions.sv
// Port checker for the cache, hole and cycle register bank.
// Assumes it is bound into scc_regs and sees nothing but its ports.
`timescale 1ns/1ps
module scc_regs_assertions (
    // Clock, reset and bus
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // Host and PCI activity
    input wire logic cpu_modified_hit,
    input wire logic pci_presnoop_cycle,
    input wire logic pci_master_toggle,
    input wire logic pci_frame_start,
    input wire logic sram_even_byte,
    // Controlled outputs
    input wire logic [2:0] write_ready_clock_q,
    input wire logic [2:0] pipe_leadoff_q,
    input wire logic [2:0] pci_read_waits_q,
    input wire logic [2:0] slave_trigger_t2_q,
    input wire logic pci_extra_wait_q,
    input wire logic sram_extra_wait_q,
    input wire logic cache_addr_latch_enable_q,
    input wire logic cache_address_bit_four_q,
    input wire logic pci_stop_q,
    input wire logic pci_claim_q,
    input wire logic inquire_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic mapped = avs_address[9:2] inside {[8'h08:8'h10]};
    sequence s_start;
        $rose(avs_read || avs_write);
    endsequence
    // One low cycle of waitrequest carries the response code.
    sequence s_answer(logic [1:0] code);
        !avs_waitrequest && avs_response == code ##1 avs_waitrequest;
    endsequence
    a_bus_mapped_ok: assert property (s_start ##0 mapped |=>
        s_answer(2'h0)) else $error("mapped access answer wrong");
    a_bus_unmapped_err: assert property (s_start ##0 !mapped |=>
        s_answer(2'h3)) else $error("unmapped access answer wrong");
    a_stop_needs_hit: assert property (pci_stop_q |->
        $past(cpu_modified_hit && pci_presnoop_cycle))
        else $error("stop without modified hit in pre-snoop");
    a_claim_after_stop: assert property (pci_claim_q |->
        $past(pci_stop_q)) else $error("claim not after stop");
    a_latch_on_hit: assert property (cache_addr_latch_enable_q ||
        cache_address_bit_four_q |-> $past(cpu_modified_hit) &&
        !(cache_addr_latch_enable_q && cache_address_bit_four_q))
        else $error("latch enable or address bit four wrong");
    a_inquire_frame: assert property (inquire_q |->
        $past(pci_frame_start)) else $error("inquire without frame");
    a_toggle_wait: assert property (pci_extra_wait_q |->
        $past(pci_master_toggle)) else $error("extra PCI wait uncaused");
    a_even_wait: assert property (sram_extra_wait_q |->
        $past(sram_even_byte)) else $error("extra SRAM wait uncaused");
    a_timing_codes: assert property (write_ready_clock_q
        inside {3'h3, 3'h4} && pipe_leadoff_q inside {3'h2, 3'h3})
        else $error("ready clock or leadoff out of range");
    a_wait_codes: assert property (pci_read_waits_q inside
        {3'h2, 3'h3, 3'h4} && slave_trigger_t2_q inside {3'h1, 3'h2})
        else $error("wait count or trigger point out of range");
endmodule
bind scc_regs scc_regs_assertions chk (.*);

// >>> sim/scc_host_model.sv
// Far side model: host CPU bus and PCI masters as seen by the bank.
// Assumes the bench calls drive_cycle; values hold until the next call.
`timescale 1ns/1ps
module scc_host_model (
    // Clock
    input wire logic clock,
    // Host and PCI activity
    output logic [31:0] host_address_bus,
    output logic skew_excess_async,
    output logic cpu_modified_hit,
    output logic pci_presnoop_cycle,
    output logic pci_master_toggle,
    output logic pci_frame_start,
    output logic sram_even_byte
);
    initial begin
        host_address_bus = 32'h0;
        {skew_excess_async, cpu_modified_hit, pci_presnoop_cycle} = 3'h0;
        {pci_master_toggle, pci_frame_start, sram_even_byte} = 3'h0;
    end
    // Flags: skew, modified hit, pre-snoop, toggle, frame, even byte.
    task automatic drive_cycle(input logic [31:0] a, input logic [5:0] f);
        @(posedge clock);
        host_address_bus <= a;
        {skew_excess_async, cpu_modified_hit, pci_presnoop_cycle,
            pci_master_toggle, pci_frame_start, sram_even_byte} <= f;
    endtask
endmodule

// >>> sim/scc_regs_bench.sv
// Self-checking bench for the cache, hole and cycle register bank.
// Assumes the design, its checker and the host model compile first.
`timescale 1ns/1ps
module scc_regs_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [9:0] avs_address = 10'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, host_address_bus;
    logic [1:0] avs_response;
    logic avs_waitrequest, skew_excess_async, cpu_modified_hit;
    logic pci_presnoop_cycle, pci_master_toggle, pci_frame_start;
    logic sram_even_byte, l1_writeback_en_q, l1_cacheable_q;
    logic l1_write_protect_q, hole_writethrough_q, hole_noncache_q;
    logic hole_remove_q, system_memory_q, parity_check_q;
    logic [2:0] write_ready_clock_q, pipe_leadoff_q, pci_read_waits_q;
    logic [2:0] pci_write_waits_q, slave_trigger_t2_q;
    logic pci_extra_wait_q, sram_extra_wait_q, sram_strobe_delay_q;
    logic sram_clock_ext_q, cache_addr_latch_enable_q, pci_stop_q;
    logic cache_address_bit_four_q, pci_claim_q, inquire_q;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [7:0] rw_mask [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h7f,
        8'hbf, 8'hff, 8'hf7, 8'hff};
    always #2 clock = ~clock;
    scc_host_model host (.*);
    scc_regs uut (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // The request rises one edge after entry, so it never merges with
    // the previous transfer and the slave sees a fresh request.
    task automatic bus(input logic w, input logic [7:0] i,
        input logic [7:0] d, input logic [3:0] be,
        output logic [31:0] r, output logic [1:0] s);
        int n;
        @(posedge clock);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            wrap_up;
        end
        r = avs_readdata;
        s = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic [1:0] s;
        bus(1'b1, i, d, 4'h1, r, s);
    endtask
    task automatic rd_chk(input logic [7:0] i, input logic [7:0] want,
        input logic [1:0] ws);
        logic [31:0] r;
        logic [1:0] s;
        bus(1'b0, i, 8'h00, 4'hf, r, s);
        check(r, {24'h0, want});
        check(32'(s), 32'(ws));
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic probe(input logic [31:0] a, input logic [5:0] f);
        host.drive_cycle(a, f);
        settle;
    endtask
    task automatic test_regs;
        logic [31:0] r;
        logic [1:0] s;
        for (int i = 0; i < 9; i++) begin
            rd_chk(8'h08 + 8'(i), 8'h00, 2'h0);
            wr(8'h08 + 8'(i), 8'hff);
            rd_chk(8'h08 + 8'(i), rw_mask[i], 2'h0);
        end
        bus(1'b1, 8'h08, 8'h00, 4'h0, r, s);
        rd_chk(8'h08, 8'hff, 2'h0);
        bus(1'b1, 8'h11, 8'hff, 4'h1, r, s);
        check(32'(s), 32'h3);
        rd_chk(8'h11, 8'h00, 2'h3);
        rd_chk(8'h07, 8'h00, 2'h3);
        for (int i = 0; i < 9; i++) wr(8'h08 + 8'(i), 8'h00);
        $display("test_regs done");
    endtask
    task automatic test_timing;
        logic [31:0] w;
        settle;
        check(32'(write_ready_clock_q), 32'h4);
        wr(8'h0c, 8'h40);
        wr(8'h10, 8'ha0);
        wr(8'h08, 8'h12);
        wr(8'h0d, 8'h80);
        wr(8'h0f, 8'h04);
        settle;
        check(32'(write_ready_clock_q), 32'h3);
        check(32'(pipe_leadoff_q), 32'h2);
        check(32'(slave_trigger_t2_q), 32'h1);
        check(32'(l1_writeback_en_q), 32'h1);
        check(32'(sram_clock_ext_q), 32'h1);
        check(32'(sram_strobe_delay_q), 32'h1);
        check(32'(parity_check_q), 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(8'h0e, {2'(c), 2'(c), 4'h8});
            settle;
            w = c == 1 ? 32'h3 : c == 2 ? 32'h2 : 32'h4;
            check(32'(pci_read_waits_q), w);
            check(32'(pci_write_waits_q), w);
            check(32'(parity_check_q), 32'h0);
        end
        for (int i = 0; i < 9; i++) wr(8'h08 + 8'(i), 8'h00);
        settle;
        check(32'(pipe_leadoff_q), 32'h3);
        check(32'(slave_trigger_t2_q), 32'h2);
        $display("test_timing done");
    endtask
    task automatic test_decode;
        wr(8'h08, 8'h01);
        wr(8'h0e, 8'h02);
        wr(8'h0d, 8'h08);
        probe(32'h000f_0000, 6'h0);
        check(32'(l1_cacheable_q), 32'h0);
        check(32'(l1_write_protect_q), 32'h1);
        probe(32'h000e_0000, 6'h0);
        check(32'(l1_cacheable_q), 32'h1);
        check(32'(l1_write_protect_q), 32'h0);
        wr(8'h10, 8'h01);
        probe(32'h000c_0000, 6'h0);
        check(32'(l1_cacheable_q), 32'h0);
        check(32'(system_memory_q), 32'h0);
        probe(32'h000e_0000, 6'h0);
        check(32'(l1_cacheable_q), 32'h0);
        probe(32'h000c_8000, 6'h0);
        check(32'(l1_cacheable_q), 32'h1);
        probe(32'h000b_ffff, 6'h0);
        check(32'(system_memory_q), 32'h1);
        probe(32'h0009_ffff, 6'h0);
        check(32'(system_memory_q), 32'h0);
        wr(8'h0a, 8'h10);
        for (int m = 1; m < 4; m++) begin
            wr(8'h09, 8'h04 | 8'(m));
            probe(32'h0088_0000, 6'h0);
            check(32'({hole_writethrough_q, hole_noncache_q, hole_remove_q}),
                32'h4 >> (m - 1));
        end
        wr(8'h09, 8'h01);
        probe(32'h0088_0000, 6'h0);
        check(32'(hole_writethrough_q), 32'h0);
        probe(32'h0080_0000, 6'h0);
        check(32'(hole_writethrough_q), 32'h1);
        wr(8'h0c, 8'h04);
        wr(8'h09, 8'h10);
        probe(32'h0800_0000, 6'h0);
        check(32'(hole_writethrough_q), 32'h1);
        probe(32'h0000_0000, 6'h0);
        check(32'(hole_writethrough_q), 32'h0);
        for (int i = 0; i < 9; i++) wr(8'h08 + 8'(i), 8'h00);
        $display("test_decode done");
    endtask
    task automatic pulse(input logic [5:0] f);
        host.drive_cycle(32'h0, f);
        host.drive_cycle(32'h0, 6'h0);
        #1;
    endtask
    task automatic test_snoop;
        // A pulse, not a held level, so no stop is pending when enabled.
        pulse(6'h18);
        check(32'(pci_stop_q), 32'h0);
        wr(8'h0f, 8'h80);
        wr(8'h0d, 8'h02);
        for (int k = 0; k < 2; k++) begin
            pulse(6'h18);
            check(32'({pci_stop_q, pci_claim_q}), 32'h2);
            check(32'({cache_addr_latch_enable_q, cache_address_bit_four_q}),
                k == 0 ? 32'h2 : 32'h1);
            @(posedge clock);
            #1;
            check(32'({pci_stop_q, pci_claim_q}), 32'h1 - k);
            wr(8'h0e, 8'h04);
            wr(8'h0d, 8'h00);
        end
        wr(8'h08, 8'h40);
        wr(8'h0e, 8'h01);
        wr(8'h0d, 8'h04);
        wr(8'h0f, 8'h20);
        pulse(6'h07);
        check(32'(inquire_q), 32'h1);
        check(32'(pci_extra_wait_q), 32'h1);
        check(32'(sram_extra_wait_q), 32'h1);
        for (int i = 0; i < 9; i++) wr(8'h08 + 8'(i), 8'h00);
        pulse(6'h07);
        check(32'(inquire_q), 32'h0);
        check(32'(pci_extra_wait_q), 32'h0);
        check(32'(sram_extra_wait_q), 32'h0);
        probe(32'h0, 6'h20);
        rd_chk(8'h0d, 8'h40, 2'h0);
        wr(8'h0d, 8'h20);
        settle;
        rd_chk(8'h0d, 8'h70, 2'h0);
        probe(32'h0, 6'h0);
        settle;
        wr(8'h0d, 8'h40);
        rd_chk(8'h0d, 8'h00, 2'h0);
        $display("test_snoop done");
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        test_regs;
        test_timing;
        test_decode;
        test_snoop;
        wrap_up;
    end
endmodule
